// ---- rtl/synth_divider_device.sv ----
// Synthesizer divider loader: parallel latch, serial shift path, dividers and test mux.
//
// Overview of operation
// RULE1: Parallel strobe rise captures feedback and post-divide.
// RULE2: Parallel strobe low makes divider latches transparent.
// RULE3: Serial clock samples data into 12-bit register.
// RULE4: Controller holds parallel strobe high during serial load.
// RULE5: Serial order: test bits, post-divide, feedback value.
// RULE6: Each serial field goes most significant bit first.
// RULE7: Serial transfer strobe fall loads shifted values.
// RULE8: Parallel strobe low forces test select zero.
// RULE9: Test select set only by serial stream.
// RULE10: Test select chooses the diagnostic output source.
// RULE11: Code 110 feeds serial clock into both dividers.
// RULE12: Output equals reference times feedback over post-divide.
// RULE13: Post-divide codes 00,01,10,11 give 2,4,8,1.
// RULE14: Feedback value is plain unsigned binary.
// RULE15: Controller keeps VCO within 800 to 1800 MHz; the host drives any feedback value it is given, with no range check.
// RULE16: Feedback counter output has unbalanced duty cycle.
// RULE17: Set parallel at power-up, tune serially later.
// RULE18: Serial clock at most 10 MHz when programming.
// RULE19: Shift register advances on serial clock rise.
// RULE20: Counters keep values between serial transfer strobes.
`timescale 1ns/10ps
module synth_divider_device
    import synth_divider_pkg::*;
(
    // System
    input  wire logic           clk_i,
    input  wire logic           reset_n_i,
    // Programming pins
    synth_pins_if.device        pins,
    // Active divider settings
    output logic [M_W-1:0]      m_o,
    output logic [N_W-1:0]      n_o,
    output logic [T_W-1:0]      t_o
);
    localparam int SYNC_W = 1 + M_W + N_W + 3;

    logic [SYNC_W-1:0]  pin_raw;
    logic [SYNC_W-1:0]  sync1;
    logic [SYNC_W-1:0]  sync2;
    logic [SYNC_W-1:0]  prev;
    logic               pl;
    logic [M_W-1:0]     pm;
    logic [N_W-1:0]     pn;
    logic               sck;
    logic               sd;
    logic               sld;
    logic               sck_rise;
    logic               sld_fall;
    logic               pl_rise;

    assign pin_raw = {pins.p_load, pins.m, pins.n, pins.s_clock, pins.s_data, pins.s_load};

    // Every pin passes two flip-flops before any logic looks at it.
    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                sync1[i] <= 1'b0;
                sync2[i] <= 1'b0;
                prev[i]  <= 1'b0;
            end else begin
                sync1[i] <= pin_raw[i];
                sync2[i] <= sync1[i];
                prev[i]  <= sync2[i];
            end
        end
    end

    assign pl       = sync2[SYNC_W-1];
    assign pm       = sync2[SYNC_W-2 -: M_W];
    assign pn       = sync2[2+N_W -: N_W];
    assign sck      = sync2[2];
    assign sd       = sync2[1];
    assign sld      = sync2[0];
    assign sck_rise = sck & ~prev[2];
    assign sld_fall = ~sld & prev[0];
    assign pl_rise  = pl & ~prev[SYNC_W-1];

    // Serial shift path and divider setting latches.
    logic [SHIFT_W-1:0] shreg;
    logic [SHIFT_W-1:0] next_shreg;
    logic [M_W-1:0]     next_m;
    logic [N_W-1:0]     next_n;
    logic [T_W-1:0]     next_t;

    always_comb begin
        next_shreg = shreg;
        next_m     = m_o; // RULE20
        next_n     = n_o;
        next_t     = t_o;
        if (sck_rise) begin
            next_shreg = {shreg[SHIFT_W-2:0], sd}; // RULE3 RULE19 RULE6
        end
        if (!pl) begin
            next_m = pm; // RULE2
            next_n = pn; // RULE2
            next_t = T_RESET; // RULE8 RULE9
        end else if (pl_rise) begin
            next_m = pm; // RULE1
            next_n = pn; // RULE1
        end else if (sld_fall) begin
            // The first bits shifted in sit at the top of the register.
            next_t = shreg[SHIFT_W-1 -: T_W]; // RULE5 RULE7 RULE9
            next_n = shreg[M_W+N_W-1 -: N_W]; // RULE5 RULE7
            next_m = shreg[M_W-1:0]; // RULE5 RULE7 RULE14
        end
        // With the parallel strobe high and no strobe edge the settings simply hold.
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shreg <= '0;
            m_o   <= M_RESET;
            n_o   <= N_RESET;
            t_o   <= T_RESET;
        end else begin
            shreg <= next_shreg;
            m_o   <= next_m;
            n_o   <= next_n;
            t_o   <= next_t;
        end
    end

    // Digital stand-in for the PLL: a phase accumulator makes VCO ticks at
    // twice the feedback value times the reference rate.
    logic [ACC_W-1:0]   ref_cnt;
    logic [ACC_W-1:0]   next_ref_cnt;
    logic               ref_half;
    logic               next_ref_half;
    logic [ACC_W-1:0]   acc;
    logic [ACC_W-1:0]   next_acc;
    logic [ACC_W:0]     acc_sum;
    logic               bypass;
    logic               vco_tick;
    logic [M_W-1:0]     m_cnt;
    logic [M_W-1:0]     next_m_cnt;
    logic [3:0]         n_cnt;
    logic [3:0]         next_n_cnt;
    logic [3:0]         n_ratio;
    logic               synth;
    logic               next_synth;
    logic [1:0]         q_cnt;
    logic [1:0]         next_q_cnt;
    logic               fb_out;
    logic               test;
    logic               next_test;

    assign pins.fout = synth;
    assign pins.test = test;

    always_comb begin
        next_ref_cnt  = ref_cnt + 1'b1;
        next_ref_half = ref_half;
        if (ref_cnt == '1) begin
            next_ref_half = ~ref_half;
        end
        acc_sum  = {1'b0, acc} + {1'b0, m_o, 1'b0}; // RULE12 RULE14
        next_acc = acc_sum[ACC_W-1:0];
        bypass   = (t_o == T_BYPASS);
        vco_tick = bypass ? sck_rise : acc_sum[ACC_W]; // RULE11
        case (n_o) // RULE13
            N_DIV2:  n_ratio = 4'h2;
            N_DIV4:  n_ratio = 4'h4;
            N_DIV8:  n_ratio = 4'h8;
            default: n_ratio = 4'h1;
        endcase
        next_m_cnt = m_cnt;
        next_n_cnt = n_cnt;
        next_synth = synth;
        next_q_cnt = q_cnt;
        if (vco_tick) begin
            // Feedback counter wraps after m_o ticks.
            if (m_cnt + 1'b1 >= m_o) begin
                next_m_cnt = '0;
            end else begin
                next_m_cnt = m_cnt + 1'b1;
            end
            // Output toggles every n_ratio ticks, so it runs at VCO / (2 * N).
            if (n_cnt + 1'b1 >= n_ratio) begin
                next_n_cnt = '0;
                next_synth = ~synth; // RULE12 RULE11
                if (!synth) begin
                    next_q_cnt = q_cnt + 1'b1;
                end
            end else begin
                next_n_cnt = n_cnt + 1'b1;
            end
        end
        // A one-tick pulse per cycle of the counter, far from 50% duty.
        fb_out = (m_cnt == '0); // RULE16
        case (t_o) // RULE10
            T_SHIFT_OUT:  next_test = shreg[SHIFT_W-1]; // RULE19
            T_ONE:        next_test = 1'b1;
            T_REF_DIV2:   next_test = ref_half;
            T_FB_OUT:     next_test = fb_out;
            T_SYNTH:      next_test = synth;
            T_ZERO:       next_test = 1'b0;
            T_BYPASS:     next_test = fb_out; // RULE11
            T_SYNTH_DIV4: next_test = q_cnt[1];
            default:      next_test = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_cnt  <= '0;
            ref_half <= 1'b0;
            acc      <= '0;
            m_cnt    <= '0;
            n_cnt    <= '0;
            synth    <= 1'b0;
            q_cnt    <= '0;
            test     <= 1'b0;
        end else begin
            ref_cnt  <= next_ref_cnt;
            ref_half <= next_ref_half;
            acc      <= next_acc;
            m_cnt    <= next_m_cnt;
            n_cnt    <= next_n_cnt;
            synth    <= next_synth;
            q_cnt    <= next_q_cnt;
            test     <= next_test;
        end
    end
endmodule

// ---- rtl/synth_divider_host.sv ----
// Controller end: drives the parallel and serial programming pins from a register port.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module synth_divider_host
    import synth_divider_pkg::*;
(
    // System
    input  wire logic               clk_i,
    input  wire logic               reset_n_i,
    // Register port
    input  wire logic [ADDR_W-1:0]  addr_i,
    input  wire logic [31:0]        wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic [31:0]             rdata_o,
    // Programming pins
    synth_pins_if.host              pins
);
    typedef enum {ST_IDLE, ST_PAR_SET, ST_SER_PREP, ST_SCK_LO, ST_SCK_HI,
                  ST_LOAD_HI, ST_LOAD_LO} state_t;

    state_t             state;
    state_t             next_state;
    logic [M_W+N_W-1:0] par_val;
    logic [M_W+N_W-1:0] next_par_val;
    logic [SHIFT_W-1:0] ser_val;
    logic [SHIFT_W-1:0] next_ser_val;
    logic [SHIFT_W-1:0] sh;
    logic [SHIFT_W-1:0] next_sh;
    logic [3:0]         bits;
    logic [3:0]         next_bits;
    logic [TMR_W-1:0]   tmr;
    logic [TMR_W-1:0]   next_tmr;
    logic               pl;
    logic               next_pl;
    logic [M_W-1:0]     m;
    logic [M_W-1:0]     next_m;
    logic [N_W-1:0]     n;
    logic [N_W-1:0]     next_n;
    logic               sck;
    logic               next_sck;
    logic               sd;
    logic               next_sd;
    logic               sld;
    logic               next_sld;
    logic [31:0]        next_rdata;
    logic               test_s1;
    logic               test_s2;
    logic               busy;
    logic               tmr_done;

    assign pins.p_load  = pl;
    assign pins.m       = m;
    assign pins.n       = n;
    assign pins.s_clock = sck;
    assign pins.s_data  = sd;
    assign pins.s_load  = sld;
    assign busy         = (state != ST_IDLE);
    assign tmr_done     = (tmr == '0);

    always_comb begin
        next_state   = state;
        next_par_val = par_val;
        next_ser_val = ser_val;
        next_sh      = sh;
        next_bits    = bits;
        next_tmr     = tmr_done ? tmr : tmr - 1'b1;
        next_pl      = pl;
        next_m       = m;
        next_n       = n;
        next_sck     = sck;
        next_sd      = sd;
        next_sld     = sld;
        next_rdata   = 32'h0000_0000;
        if (wr_i && addr_i == REG_PAR) begin
            next_par_val = wdata_i[M_W+N_W-1:0];
        end
        if (wr_i && addr_i == REG_SER) begin
            next_ser_val = wdata_i[SHIFT_W-1:0];
        end
        if (rd_i) begin
            case (addr_i)
                REG_PAR:  next_rdata = {{(32-M_W-N_W){1'b0}}, par_val};
                REG_SER:  next_rdata = {{(32-SHIFT_W){1'b0}}, ser_val};
                REG_STAT: begin
                    next_rdata[STAT_BUSY_BIT]  = busy;
                    next_rdata[STAT_TEST_BIT]  = test_s2;
                    next_rdata[STAT_PLOAD_BIT] = pl;
                end
                default:  next_rdata = 32'h0000_0000;
            endcase
        end
        case (state)
            ST_IDLE: begin
                if (wr_i && addr_i == REG_CTRL && wdata_i[CTRL_PAR_BIT]) begin
                    // Latch goes transparent while the new values settle.
                    next_pl    = 1'b0; // RULE17
                    next_m     = par_val[M_W-1:0];
                    next_n     = par_val[M_W+N_W-1:M_W];
                    next_tmr   = TMR_W'(WAIT_CYC - 1);
                    next_state = ST_PAR_SET;
                end else if (wr_i && addr_i == REG_CTRL && wdata_i[CTRL_SER_BIT]) begin
                    next_pl    = 1'b1; // RULE4
                    next_sh    = ser_val; // RULE5
                    next_bits  = '0;
                    next_tmr   = TMR_W'(WAIT_CYC - 1);
                    next_state = ST_SER_PREP;
                end
            end
            ST_PAR_SET: begin
                if (tmr_done) begin
                    next_pl    = 1'b1; // RULE1
                    next_state = ST_IDLE;
                end
            end
            ST_SER_PREP: begin
                if (tmr_done) begin
                    next_sd    = sh[SHIFT_W-1]; // RULE6
                    next_tmr   = TMR_W'(SCLK_HALF_CYC - 1);
                    next_state = ST_SCK_LO;
                end
            end
            ST_SCK_LO: begin
                if (tmr_done) begin
                    next_sck   = 1'b1; // RULE18
                    next_tmr   = TMR_W'(SCLK_HALF_CYC - 1);
                    next_state = ST_SCK_HI;
                end
            end
            ST_SCK_HI: begin
                if (tmr_done) begin
                    next_sck  = 1'b0;
                    next_sh   = {sh[SHIFT_W-2:0], 1'b0};
                    next_sd   = sh[SHIFT_W-2];
                    next_bits = bits + 1'b1;
                    next_tmr  = TMR_W'(SCLK_HALF_CYC - 1);
                    if (bits == 4'(SHIFT_W - 1)) begin
                        next_state = ST_LOAD_HI;
                    end else begin
                        next_state = ST_SCK_LO;
                    end
                end
            end
            ST_LOAD_HI: begin
                if (tmr_done) begin
                    next_sld   = 1'b1; // RULE7
                    next_tmr   = TMR_W'(PULSE_CYC - 1);
                    next_state = ST_LOAD_LO;
                end
            end
            ST_LOAD_LO: begin
                if (tmr_done) begin
                    next_sld   = 1'b0; // RULE7
                    next_tmr   = TMR_W'(PULSE_CYC - 1);
                    next_state = ST_PAR_SET;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state   <= ST_IDLE;
            par_val <= '0;
            ser_val <= '0;
            sh      <= '0;
            bits    <= '0;
            tmr     <= '0;
            pl      <= 1'b0;
            m       <= M_RESET;
            n       <= N_RESET;
            sck     <= 1'b0;
            sd      <= 1'b0;
            sld     <= 1'b0;
            rdata_o <= 32'h0000_0000;
            test_s1 <= 1'b0;
            test_s2 <= 1'b0;
        end else begin
            state   <= next_state;
            par_val <= next_par_val;
            ser_val <= next_ser_val;
            sh      <= next_sh;
            bits    <= next_bits;
            tmr     <= next_tmr;
            pl      <= next_pl;
            m       <= next_m;
            n       <= next_n;
            sck     <= next_sck;
            sd      <= next_sd;
            sld     <= next_sld;
            rdata_o <= next_rdata;
            test_s1 <= pins.test;
            test_s2 <= test_s1;
        end
    end
endmodule

// ---- rtl/synth_divider_pkg.sv ----
// Shared constants for the synthesizer divider programming link.
package synth_divider_pkg;
    localparam int M_W = 7;
    localparam int N_W = 2;
    localparam int T_W = 3;
    localparam int SHIFT_W = T_W + N_W + M_W;
    // Clock and pin timing.
    localparam int CLK_PERIOD_NS = 20;
    localparam int CLK_MHZ = 50;
    localparam int SCLK_MAX_MHZ = 10;
    localparam int PULSE_MIN_NS = 50;
    localparam int SETUP_NS = 20;
    localparam int SCLK_HALF_CYC = (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
    localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_CYC = (PULSE_CYC > SETUP_CYC) ? PULSE_CYC : SETUP_CYC;
    localparam int TMR_W = 4;
    // Reference model: the reference period is 2**ACC_W system clocks.
    localparam int ACC_W = 8;
    // Values after reset.
    localparam logic [M_W-1:0] M_RESET = 7'h00;
    localparam logic [N_W-1:0] N_RESET = 2'h0;
    localparam logic [T_W-1:0] T_RESET = 3'h0;
    // Post-divide select codes.
    localparam logic [N_W-1:0] N_DIV2 = 2'h0;
    localparam logic [N_W-1:0] N_DIV4 = 2'h1;
    localparam logic [N_W-1:0] N_DIV8 = 2'h2;
    localparam logic [N_W-1:0] N_DIV1 = 2'h3;
    // Test-node select codes.
    localparam logic [T_W-1:0] T_SHIFT_OUT = 3'h0;
    localparam logic [T_W-1:0] T_ONE = 3'h1;
    localparam logic [T_W-1:0] T_REF_DIV2 = 3'h2;
    localparam logic [T_W-1:0] T_FB_OUT = 3'h3;
    localparam logic [T_W-1:0] T_SYNTH = 3'h4;
    localparam logic [T_W-1:0] T_ZERO = 3'h5;
    localparam logic [T_W-1:0] T_BYPASS = 3'h6;
    localparam logic [T_W-1:0] T_SYNTH_DIV4 = 3'h7;
    // Controller register map.
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PAR = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SER = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STAT = 8'h0C;
    localparam int CTRL_PAR_BIT = 0;
    localparam int CTRL_SER_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TEST_BIT = 1;
    localparam int STAT_PLOAD_BIT = 2;
endpackage

// ---- rtl/synth_pins_if.sv ----
// Programming pins between the controller and the synthesizer.
`timescale 1ns/10ps
interface synth_pins_if;
    import synth_divider_pkg::*;
    logic           p_load;
    logic [M_W-1:0] m;
    logic [N_W-1:0] n;
    logic           s_clock;
    logic           s_data;
    logic           s_load;
    logic           fout;
    logic           test;
    modport device (input p_load, m, n, s_clock, s_data, s_load, output fout, test);
    modport host (output p_load, m, n, s_clock, s_data, s_load, input fout, test);
endinterface

// ---- verification/synth_divider_monitor.sv ----
// Concurrent checks on the programming pins and the active divider settings.
`timescale 1ns/10ps
module synth_divider_monitor
    import synth_divider_pkg::*;
(
    // System
    input  wire logic           clk_i,
    input  wire logic           reset_n_i,
    // Pins and settings
    input  wire logic           p_load,
    input  wire logic [M_W-1:0] m,
    input  wire logic [N_W-1:0] n,
    input  wire logic           s_clock,
    input  wire logic           s_data,
    input  wire logic           s_load,
    input  wire logic           fout,
    input  wire logic           test,
    input  wire logic [M_W-1:0] m_o,
    input  wire logic [N_W-1:0] n_o,
    input  wire logic [T_W-1:0] t_o
);
    logic               s_clock_q;
    logic [SHIFT_W-1:0] shadow;

    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Mirror of the serial shift register, advanced on each rising serial clock.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_clock_q <= 1'b0;
            shadow    <= '0;
        end else begin
            s_clock_q <= s_clock;
            if (s_clock && !s_clock_q) begin
                shadow <= {shadow[SHIFT_W-2:0], s_data};
            end
        end
    end

    a_tsel_forced_zero: assert property ((!p_load)[*5] |-> t_o == T_RESET)
        else $error("test select not zero while latch strobe low");
    a_latch_transparent: assert property ((!p_load && $stable(m) && $stable(n))[*5]
        |-> m_o == m && n_o == n)
        else $error("settings do not follow pins while transparent");
    a_par_capture: assert property ($rose(p_load) |-> ##5 m_o == $past(m, 5) && n_o == $past(n, 5))
        else $error("settings differ from pins at strobe rise");
    a_hold_between: assert property ((p_load && !s_load)[*6]
        |-> $stable(m_o) && $stable(n_o) && $stable(t_o))
        else $error("settings changed without a load strobe");
    a_serial_load: assert property ($fell(s_load) && p_load |-> ##5 {t_o, n_o, m_o} == shadow)
        else $error("serial load moved wrong values");
    a_const_one: assert property ((t_o == T_ONE)[*2] |-> test)
        else $error("diagnostic output not one");
    a_const_zero: assert property ((t_o == T_ZERO)[*2] |-> !test)
        else $error("diagnostic output not zero");
    a_shift_out: assert property ((t_o == T_SHIFT_OUT && $stable(shadow))[*6]
        |-> test == shadow[SHIFT_W-1])
        else $error("diagnostic output not shift register out");
    a_bypass_quiet: assert property ((t_o == T_BYPASS && !s_clock)[*6] |-> $stable(fout))
        else $error("bypass output moved without serial clock");
endmodule

// ---- verification/tb.sv ----
// Self-checking bench: controller and synthesizer joined through the pin interface.
`timescale 1ns/10ps
module tb;
    import synth_divider_pkg::*;
    logic              clk_i;
    logic              reset_n_i;
    logic [ADDR_W-1:0] addr_i;
    logic [31:0]       wdata_i;
    logic              wr_i;
    logic              rd_i;
    logic [31:0]       rdata_o;
    logic [M_W-1:0]    m_o;
    logic [N_W-1:0]    n_o;
    logic [T_W-1:0]    t_o;
    logic              cnt_en;
    logic              fout_q;
    logic              test_q;
    int                fout_tgl;
    int                test_tgl;
    int                num_errors;
    int                cmp_count;
    int                ratio [4] = '{2, 4, 8, 1};

    synth_pins_if synth_pins_if_inst ();
    synth_divider_host synth_divider_host_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pins(synth_pins_if_inst));
    synth_divider_device synth_divider_device_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .pins(synth_pins_if_inst), .m_o(m_o), .n_o(n_o), .t_o(t_o));
    synth_divider_monitor synth_divider_monitor_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .p_load(synth_pins_if_inst.p_load), .m(synth_pins_if_inst.m),
        .n(synth_pins_if_inst.n), .s_clock(synth_pins_if_inst.s_clock),
        .s_data(synth_pins_if_inst.s_data), .s_load(synth_pins_if_inst.s_load),
        .fout(synth_pins_if_inst.fout), .test(synth_pins_if_inst.test),
        .m_o(m_o), .n_o(n_o), .t_o(t_o));

    always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

    always @(posedge clk_i) begin
        fout_q <= synth_pins_if_inst.fout;
        test_q <= synth_pins_if_inst.test;
        fout_tgl += int'(cnt_en && (synth_pins_if_inst.fout !== fout_q));
        test_tgl += int'(cnt_en && (synth_pins_if_inst.test !== test_q));
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic check_range(input string what, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
        @(posedge clk_i);
    endtask

    // Polls busy, then leaves time for the device's pin synchronisers.
    task automatic wait_idle();
        logic [31:0] st;
        for (int i = 0; i < 300; i++) begin
            rd_reg(REG_STAT, st);
            if (st[STAT_BUSY_BIT] === 1'b0) break;
        end
        check("busy", 32'h0, 32'(st[STAT_BUSY_BIT]));
        repeat (6) @(posedge clk_i);
    endtask

    task automatic ser_load(input logic [T_W-1:0] t, input logic [N_W-1:0] nv,
                            input logic [M_W-1:0] mv);
        wr_reg(REG_SER, 32'({t, nv, mv}));
        wr_reg(REG_CTRL, 32'h1 << CTRL_SER_BIT);
        wait_idle();
    endtask

    task automatic test_reset();
        logic [31:0] d;
        check("settings", 32'h0, 32'({t_o, n_o, m_o}));
        rd_reg(REG_CTRL, d);
        check("ctrl read", 32'h0, d);
        rd_reg(8'h10, d);
        check("unmapped read", 32'h0, d);
        rd_reg(REG_STAT, d);
        check("status", 32'h0, d);
        $display("test_reset done");
    endtask

    task automatic test_parallel();
        logic [31:0] d;
        wr_reg(REG_PAR, 32'({N_DIV2, 7'h30}));
        wr_reg(REG_CTRL, 32'h1 << CTRL_PAR_BIT);
        wait_idle();
        check("settings", 32'({T_RESET, N_DIV2, 7'h30}), 32'({t_o, n_o, m_o}));
        wr_reg(REG_PAR, 32'({N_DIV8, 7'h7F}));
        repeat (6) @(posedge clk_i);
        check("held", 32'({T_RESET, N_DIV2, 7'h30}), 32'({t_o, n_o, m_o}));
        rd_reg(REG_STAT, d);
        check("strobe", 32'h1 << STAT_PLOAD_BIT, d);
        $display("test_parallel done");
    endtask

    task automatic test_serial();
        logic [31:0] d;
        for (int i = 0; i < 8; i++) begin
            ser_load(3'(i), 2'(i), 7'(i * 19 + 42));
            check("settings", 32'({3'(i), 2'(i), 7'(i * 19 + 42)}), 32'({t_o, n_o, m_o}));
            rd_reg(REG_STAT, d);
            if (i == 1 || i == 5) check("test", 32'(i == 1), 32'(d[STAT_TEST_BIT]));
        end
        $display("test_serial done");
    endtask

    task automatic test_override();
        ser_load(T_ONE, N_DIV4, 7'h20);
        wr_reg(REG_PAR, 32'({N_DIV1, 7'h19}));
        wr_reg(REG_CTRL, 32'h1 << CTRL_PAR_BIT);
        wait_idle();
        check("settings", 32'({T_RESET, N_DIV1, 7'h19}), 32'({t_o, n_o, m_o}));
        $display("test_override done");
    endtask

    task automatic test_bypass();
        for (int c = 0; c < 4; c++) begin
            ser_load(T_BYPASS, 2'(c), 7'h05);
            fout_tgl = 0;
            cnt_en <= 1'b1;
            ser_load(T_BYPASS, 2'(c), 7'h05);
            cnt_en <= 1'b0;
            check_range("bypass", 12 / ratio[c], (11 + ratio[c]) / ratio[c], fout_tgl);
        end
        $display("test_bypass done");
    endtask

    task automatic test_synth();
        for (int c = 0; c < 4; c++) begin
            ser_load(T_SYNTH, 2'(c), 7'h10);
            fout_tgl = 0;
            test_tgl = 0;
            cnt_en <= 1'b1;
            repeat (1024) @(posedge clk_i);
            cnt_en <= 1'b0;
            @(posedge clk_i);
            check_range("fout", 128 / ratio[c] - 1, 128 / ratio[c] + 1, fout_tgl);
            check_range("diag", 128 / ratio[c] - 2, 128 / ratio[c] + 2, test_tgl);
        end
        $display("test_synth done");
    endtask

    // The reference-half, feedback and synth-divide-by-four diagnostic sources are judged by their edge counts over four reference periods.
    task automatic test_diag();
        logic [T_W-1:0] code     [3] = '{T_REF_DIV2, T_FB_OUT, T_SYNTH_DIV4};
        int             diag_exp [3] = '{4, 16, 32};
        for (int k = 0; k < 3; k++) begin
            ser_load(code[k], N_DIV1, 7'h10);
            test_tgl = 0;
            cnt_en <= 1'b1;
            repeat (1024) @(posedge clk_i);
            cnt_en <= 1'b0;
            @(posedge clk_i);
            check_range("diag source", diag_exp[k] - 2, diag_exp[k] + 2, test_tgl);
        end
        $display("test_diag done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(1_000_000);
        num_errors++;
        finish_test();
    end

    initial begin
        clk_i     = 1'b0;
        reset_n_i = 1'b0;
        addr_i    = '0;
        wdata_i   = '0;
        wr_i      = 1'b0;
        rd_i      = 1'b0;
        cnt_en    = 1'b0;
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        test_reset();
        test_parallel();
        test_serial();
        test_override();
        test_bypass();
        test_synth();
        test_diag();
        finish_test();
    end
endmodule
